/* rtl/tcfp_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the fast compare/PWM timer.
 * Assumes byte addresses on a 32-bit classic Wishbone slave port.
 */
`ifndef TCFP_MAP_SVH
`define TCFP_MAP_SVH

// ======================================================================
// register byte addresses
`define TCFP_ADR_CTRL 8'h30
`define TCFP_ADR_CNT 8'h34
`define TCFP_ADR_CMP 8'h38
`define TCFP_ADR_TOP 8'h3C
`define TCFP_ADR_FLAG 8'h40
`define TCFP_ADR_MASK 8'h44
`define TCFP_ADR_DIR 8'h48

// ======================================================================
// timer_control fields
`define TCFP_CTRL_CLR_BIT 7
`define TCFP_CTRL_PWM_BIT 6
`define TCFP_CTRL_ACT_HI 5
`define TCFP_CTRL_ACT_LO 4
`define TCFP_CTRL_CS_HI 3
`define TCFP_CTRL_CS_LO 0

// ======================================================================
// flag, mask and direction fields
`define TCFP_FLAG_OVF_BIT 0
`define TCFP_FLAG_CMP_BIT 1
`define TCFP_MASK_GIE_BIT 7
`define TCFP_DIR_PIN_BIT 0

// ======================================================================
// reset values
`define TCFP_RST_CTRL 8'h00
`define TCFP_RST_BYTE 8'h00

// ======================================================================
// timing: clk_i is the fast clock, the system clock is 1 in 16
`define TCFP_FAST_MULT 16
`define TCFP_PRE_W 14

`endif

/* rtl/tcfp_pkg.sv */
/*
 * Types shared by the fast compare/PWM timer modules.
 * Assumes tcfp_map.svh supplies the numeric constants.
 */
package tcfp_pkg;
   typedef logic [7:0] tcfp_byte_t;
   // order follows the two-bit compare action code 00..11
   typedef enum logic [1:0] {
      ACT_NONE,
      ACT_TOGGLE,
      ACT_LOW,
      ACT_HIGH
   } tcfp_act_t;
endpackage : tcfp_pkg

/* rtl/tcfp_prescale.sv */
/*
 * Clock-enable generator: system clock tick and timer count tick.
 * Assumes clk_i is the fast peripheral clock, sixteen times the
 * system clock.
 */
`timescale 1ns/10ps
`include "tcfp_map.svh"
module tcfp_prescale import tcfp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // source selection
   input wire logic [3:0] sel_i,
   // enables
   output logic sys_tick_o,
   output logic timer_tick_o
);
   logic [`TCFP_PRE_W-1:0] pre_ff;
   logic [`TCFP_PRE_W:0] tap;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + `TCFP_PRE_W'(1);
      end
   end

   // ===================================================================
   // tap k fires once every 2**k fast cycles
   assign tap[0] = 1'b1;
   genvar k;
   generate
      for (k = 1; k <= `TCFP_PRE_W; k = k + 1) begin : g_tap
         assign tap[k] = &pre_ff[k-1:0];
      end
   endgenerate

   // system clock is the fast clock divided by sixteen
   assign sys_tick_o = tap[4];
   // code 0 stops, code n divides the fast clock by 2**(n-1)
   assign timer_tick_o = (sel_i == 4'h0) ? 1'b0 : tap[sel_i - 4'h1];
endmodule : tcfp_prescale

/* rtl/tcfp_bufreg.sv */
/*
 * Eight-bit register with a holding stage that is moved into use
 * only on a latch strobe while buffering is on.
 * Assumes write and latch strobes are single-cycle on clk_i.
 */
`timescale 1ns/10ps
`include "tcfp_map.svh"
module tcfp_bufreg import tcfp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic wr_i,
   input wire tcfp_byte_t wdata_i,
   input wire logic buffered_i,
   input wire logic latch_i,
   // values
   output tcfp_byte_t hold_o,
   output tcfp_byte_t active_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_o <= `TCFP_RST_BYTE;
      end else if (wr_i) begin
         hold_o <= wdata_i;
      end
   end

   // leaving buffered mode flushes a pending value at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_o <= `TCFP_RST_BYTE;
      end else if (wr_i && !buffered_i) begin
         active_o <= wdata_i;
      end else if (!buffered_i || latch_i) begin
         active_o <= hold_o;
      end
   end
endmodule : tcfp_bufreg

/* rtl/tcfp_timer.sv */
/*
 * Eight-bit up timer with compare output and buffered PWM, as a
 * classic Wishbone slave.
 * Assumes clk_i is the fast peripheral clock (16x system clock) and
 * that the interrupt controller consumes the two request levels.
 */
`timescale 1ns/10ps
`include "tcfp_map.svh"
module tcfp_timer import tcfp_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // compare output pin
   output logic cmp_pin_o,
   output logic cmp_pin_oe_o,
   // interrupt requests
   output logic irq_ovf_o,
   output logic irq_cmp_o
);
   // ===================================================================
   // declarations
   tcfp_byte_t ctrl_ff;
   tcfp_byte_t cnt_ff;
   tcfp_byte_t flag_ff;
   tcfp_byte_t mask_ff;
   tcfp_byte_t dir_ff;
   tcfp_byte_t cmp_hold;
   tcfp_byte_t cmp_act;
   tcfp_byte_t top_hold;
   tcfp_byte_t top_act;
   tcfp_byte_t nxt_cnt;
   tcfp_byte_t rd_mux;
   tcfp_byte_t wbyte;
   tcfp_act_t act;
   logic req;
   logic wr_acc;
   logic ctrl_wr;
   logic cnt_wr;
   logic cmp_wr;
   logic top_wr;
   logic flag_wr;
   logic sys_tick;
   logic timer_tick;
   logic pwm;
   logic adv_ok;
   logic match_ev;
   logic ovf_ev;
   logic zero_ev;
   logic clr_do;
   logic cmp_pend_ff;
   logic ovf_pend_ff;
   logic pin_ff;
   logic hi;

   // ===================================================================
   // wishbone slave: ack one cycle after the strobe, write on ack
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_acc = req & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign ctrl_wr = wr_acc & ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_CTRL);
   assign cnt_wr = wr_acc & ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_CNT);
   assign cmp_wr = wr_acc & ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_CMP);
   assign top_wr = wr_acc & ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_TOP);
   assign flag_wr = wr_acc & ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_FLAG);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   always_comb begin
      case ({wb_adr_i[7:2], 2'b00})
         `TCFP_ADR_CTRL: rd_mux = ctrl_ff;
         `TCFP_ADR_CNT: rd_mux = cnt_ff;
         `TCFP_ADR_CMP: rd_mux = cmp_hold;
         `TCFP_ADR_TOP: rd_mux = top_hold;
         `TCFP_ADR_FLAG: rd_mux = flag_ff;
         `TCFP_ADR_MASK: rd_mux = mask_ff;
         `TCFP_ADR_DIR: rd_mux = dir_ff;
         default: rd_mux = 8'h00;
      endcase
   end

   // read data is captured with the ack, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req & ~wb_ack_o) begin
         wb_dat_o <= {24'h000000, rd_mux};
      end
   end

   // ===================================================================
   // plain control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `TCFP_RST_CTRL;
      end else if (ctrl_wr) begin
         ctrl_ff <= wbyte;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_ff <= `TCFP_RST_BYTE;
         dir_ff <= `TCFP_RST_BYTE;
      end else if (wr_acc) begin
         if ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_MASK) begin
            mask_ff <= wbyte;
         end
         if ({wb_adr_i[7:2], 2'b00} == `TCFP_ADR_DIR) begin
            dir_ff <= wbyte;
         end
      end
   end

   assign pwm = ctrl_ff[`TCFP_CTRL_PWM_BIT];
   assign act = tcfp_act_t'(ctrl_ff[`TCFP_CTRL_ACT_HI:`TCFP_CTRL_ACT_LO]);

   // ===================================================================
   // clock enables: clk_i stands for the 16x fast clock
   tcfp_prescale u_pre (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(ctrl_ff[`TCFP_CTRL_CS_HI:`TCFP_CTRL_CS_LO]),
      .sys_tick_o(sys_tick),
      .timer_tick_o(timer_tick)
   );

   // ===================================================================
   // buffered compare and period registers
   tcfp_bufreg u_cmp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(cmp_wr),
      .wdata_i(wbyte),
      .buffered_i(pwm),
      .latch_i(ovf_ev),
      .hold_o(cmp_hold),
      .active_o(cmp_act)
   );

   tcfp_bufreg u_top (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(top_wr),
      .wdata_i(wbyte),
      .buffered_i(pwm),
      .latch_i(ovf_ev),
      .hold_o(top_hold),
      .active_o(top_act)
   );

   // ===================================================================
   // counter and events
   // a software write owns the cycle, so it never counts as a match
   assign adv_ok = timer_tick & ~cnt_wr;
   assign nxt_cnt = (pwm && cnt_ff == top_act) ? 8'h00
                  : cnt_ff + 8'h01;
   assign match_ev = adv_ok & (nxt_cnt == cmp_act);
   assign ovf_ev = adv_ok & (pwm ? (nxt_cnt == top_act)
                                 : (cnt_ff == 8'hFF));
   assign zero_ev = adv_ok & pwm & (nxt_cnt == 8'h00);
   // the clear waits for the next system clock cycle
   assign clr_do = sys_tick & cmp_pend_ff & ~pwm
                 & ctrl_ff[`TCFP_CTRL_CLR_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= 8'h00;
      end else if (cnt_wr) begin
         cnt_ff <= wbyte;
      end else if (clr_do) begin
         cnt_ff <= 8'h00;
      end else if (adv_ok) begin
         cnt_ff <= nxt_cnt;
      end
   end

   // events are held until the next system clock tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_pend_ff <= 1'b0;
         ovf_pend_ff <= 1'b0;
      end else begin
         cmp_pend_ff <= match_ev | (cmp_pend_ff & ~sys_tick);
         ovf_pend_ff <= ovf_ev | (ovf_pend_ff & ~sys_tick);
      end
   end

   // ===================================================================
   // flags: write one to clear, a set in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 8'h00;
      end else begin
         flag_ff[`TCFP_FLAG_OVF_BIT] <= (flag_ff[`TCFP_FLAG_OVF_BIT]
            & ~(flag_wr & wbyte[`TCFP_FLAG_OVF_BIT]))
            | (sys_tick & ovf_pend_ff);
         flag_ff[`TCFP_FLAG_CMP_BIT] <= (flag_ff[`TCFP_FLAG_CMP_BIT]
            & ~(flag_wr & wbyte[`TCFP_FLAG_CMP_BIT]))
            | (sys_tick & cmp_pend_ff);
      end
   end

   assign irq_ovf_o = flag_ff[`TCFP_FLAG_OVF_BIT]
      & mask_ff[`TCFP_FLAG_OVF_BIT] & mask_ff[`TCFP_MASK_GIE_BIT];
   assign irq_cmp_o = flag_ff[`TCFP_FLAG_CMP_BIT]
      & mask_ff[`TCFP_FLAG_CMP_BIT] & mask_ff[`TCFP_MASK_GIE_BIT];

   // ===================================================================
   // compare output pin
   // hi is the level set at zero in PWM; action 11 inverts it
   assign hi = (act == ACT_LOW);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_ff <= 1'b0;
      end else if (pwm) begin
         if (act == ACT_LOW || act == ACT_HIGH) begin
            if (cmp_act == 8'h00) begin
               pin_ff <= ~hi;
            end else if (cmp_act == top_act) begin
               pin_ff <= hi;
            end else if (match_ev) begin
               pin_ff <= ~hi;
            end else if (zero_ev) begin
               pin_ff <= hi;
            end
         end
      end else if (match_ev) begin
         case (act)
            ACT_TOGGLE: pin_ff <= ~pin_ff;
            ACT_LOW: pin_ff <= 1'b0;
            ACT_HIGH: pin_ff <= 1'b1;
            default: pin_ff <= pin_ff;
         endcase
      end
   end

   // PWM codes 00/01 and normal code 00 leave the pin to the port
   assign cmp_pin_o = pin_ff;
   assign cmp_pin_oe_o = dir_ff[`TCFP_DIR_PIN_BIT]
      & (pwm ? act[1] : (act != ACT_NONE));

   // ===================================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_stop_holds: assert property (
      (ctrl_ff[3:0] == 4'h0) && !cnt_wr && !clr_do |=> $stable(cnt_ff))
      else $error("counter moved while stopped");

   a_fast_counts: assert property (
      (ctrl_ff[3:0] == 4'h1) && !cnt_wr && !clr_do && !pwm
      |=> cnt_ff == $past(cnt_ff) + 8'h01)
      else $error("fast source did not count every cycle");

   a_clear_match: assert property (
      match_ev && !pwm && ctrl_ff[7]
      |-> ##[1:17] (cnt_ff == 8'h00 || !ctrl_ff[7] || pwm || cnt_wr))
      else $error("counter not cleared after match");

   a_match_toggle: assert property (
      match_ev && !pwm && act == ACT_TOGGLE |=> pin_ff != $past(pin_ff))
      else $error("pin did not toggle on match");

   a_match_low: assert property (
      match_ev && !pwm && act == ACT_LOW |=> !pin_ff)
      else $error("pin not driven low on match");

   a_oe_gated: assert property (
      !dir_ff[0] |-> !cmp_pin_oe_o)
      else $error("pin driven with direction input");

   a_write_nomatch: assert property (
      cnt_wr |=> !cmp_pend_ff || $past(cmp_pend_ff))
      else $error("counter write raised a match");

   a_cmp_flag: assert property (
      match_ev && !(flag_wr && wbyte[1]) |-> ##[1:17] flag_ff[1])
      else $error("compare flag not set after match");

   a_pwm_wrap: assert property (
      pwm && adv_ok && cnt_ff == top_act && !clr_do |=> cnt_ff == 8'h00)
      else $error("PWM counter did not restart at top");

   a_pwm_ovf: assert property (
      pwm && adv_ok && cnt_ff != top_act && cnt_ff + 8'h01 == top_act
      |-> ##[1:17] flag_ff[0])
      else $error("overflow flag not set at period top");

   a_norm_wrap: assert property (
      !pwm && adv_ok && cnt_ff == 8'hFF |-> ##[1:17] flag_ff[0])
      else $error("overflow flag not set on wrap");

   a_buf_hold: assert property (
      pwm && $past(pwm) && cmp_wr && !ovf_ev |=> $stable(cmp_act))
      else $error("buffered compare used before top");

   a_pwm_const: assert property (
      pwm && act == ACT_LOW && cmp_act == 8'h00 && $past(cmp_act) == 8'h00
      && $past(pwm) && $past(act) == ACT_LOW |-> !pin_ff)
      else $error("pin not held low at compare zero");

   a_ovf_req: assert property (
      flag_ff[0] && mask_ff[0] && mask_ff[7] |-> irq_ovf_o)
      else $error("overflow request missing");

   c_match: cover property (match_ev && !pwm);
   c_pwm_top: cover property (pwm && ovf_ev);
   c_ctc_clear: cover property (clr_do);
   c_irq_cmp: cover property (irq_cmp_o);
   c_pwm_hold: cover property (pwm && cmp_wr);
endmodule : tcfp_timer

/* bench/tcfp_load.sv */
/*
 * Load on the compare output pin: a line with a pull-down that counts
 * the clock cycles it spends high.
 * Assumes one clock and a single-cycle clear from the bench.
 */
`timescale 1ns/10ps
module tcfp_load (
   // clock and control
   input wire logic clk_i,
   input wire logic clr_i,
   // pin from the timer
   input wire logic pin_i,
   input wire logic oe_i,
   // observed line
   output logic line_o,
   output logic [15:0] high_cnt_o
);
   // ===================================================================
   // line level and high-time counter
   // an undriven line falls to the pull-down, never the last level
   assign line_o = oe_i ? pin_i : 1'b0;
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         high_cnt_o <= 16'h0000;
      end else if (line_o) begin
         high_cnt_o <= high_cnt_o + 16'h0001;
      end
   end
endmodule : tcfp_load

/* bench/tcfp_timer_tb_top.sv */
/*
 * Self-checking bench for the compare/PWM timer.
 * Assumes the register map of tcfp_map.svh and a 100 MHz clk_i.
 */
`timescale 1ns/10ps
`include "tcfp_map.svh"
module tcfp_timer_tb_top import tcfp_pkg::*;;
   localparam logic [7:0] A_CTL = `TCFP_ADR_CTRL;
   localparam logic [7:0] A_CNT = `TCFP_ADR_CNT;
   localparam logic [7:0] A_CMP = `TCFP_ADR_CMP;
   localparam logic [7:0] A_TOP = `TCFP_ADR_TOP;
   localparam logic [7:0] A_FLG = `TCFP_ADR_FLAG;
   localparam logic [7:0] A_MSK = `TCFP_ADR_MASK;
   localparam logic [7:0] A_DIR = `TCFP_ADR_DIR;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, cmp_pin_o, cmp_pin_oe_o, irq_ovf_o, irq_cmp_o;
   logic clr = 1'b0;
   logic line;
   logic [15:0] high_cnt;
   logic [31:0] rs = 32'h8B673E1C;
   logic [8:0] exp_q[$];
   logic [8:0] e_m;
   int n_errors = 0;
   int checks = 0;

   always #5 clk_i = ~clk_i;

   tcfp_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .cmp_pin_o(cmp_pin_o),
      .cmp_pin_oe_o(cmp_pin_oe_o), .irq_ovf_o(irq_ovf_o),
      .irq_cmp_o(irq_cmp_o));
   tcfp_load load_u (.clk_i(clk_i), .clr_i(clr), .pin_i(cmp_pin_o),
      .oe_i(cmp_pin_oe_o), .line_o(line), .high_cnt_o(high_cnt));

   // ===================================================================
   // checking helpers
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic check(input string nm, input logic [15:0] ex,
                        input logic [15:0] got);
      checks++;
      if (got !== ex) begin
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
         n_errors++;
      end
   endtask : check

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   // ===================================================================
   // classic wishbone master, waits for ack under a bound
   task automatic bus(input logic we, input logic [7:0] adr,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o[7:0];
      if (n >= 20) begin
         n_errors++;
         test_done();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, adr, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] adr, input logic [7:0] ex);
      logic [7:0] q;
      exp_q.push_back({1'b1, ex});
      bus(1'b0, adr, 8'h00, q);
   endtask : rd

   // read data is judged here, oldest note first
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         e_m = exp_q.pop_front();
         if (e_m[8]) check("read data", {8'h00, e_m[7:0]}, wb_dat_o[15:0]);
      end
   end

   // ===================================================================
   // scenarios
   initial begin
      logic [7:0] q;
      logic [7:0] cv[4];
      int hi;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) rd(A_CTL + 8'(4 * i), 8'h00);
      wr(8'h50, 8'hA5);
      rd(8'h50, 8'h00);
      rs = xs(rs);
      wr(A_CNT, rs[7:0]);
      repeat (40) @(posedge clk_i);
      rd(A_CNT, rs[7:0]);
      // a write making the values equal while counting gives no match
      wr(A_DIR, 8'h01);
      wr(A_CMP, 8'h40);
      wr(A_CNT, 8'h80);
      wr(A_CTL, 8'h31);
      wr(A_CNT, 8'h40);
      repeat (40) @(posedge clk_i);
      wr(A_CTL, 8'h30);
      rd(A_FLG, 8'h00);
      check("pin", 16'h0000, 16'(line));
      // action codes: high, low, toggle; mask stays off meanwhile
      wr(A_CMP, 8'h10);
      for (int a = 3; a > 0; a--) begin
         wr(A_FLG, 8'h03);
         wr(A_CNT, 8'h0E);
         wr(A_CTL, {2'b00, 2'(a), 4'h1});
         repeat (40) @(posedge clk_i);
         wr(A_CTL, {2'b00, 2'(a), 4'h0});
         check("oe", 16'h0001, 16'(cmp_pin_oe_o));
         check("pin", 16'(a != 2), 16'(line));
         rd(A_FLG, 8'h02);
      end
      wr(A_DIR, 8'h00);
      @(posedge clk_i);
      check("released line", 16'h0000, 16'(line));
      wr(A_MSK, 8'h82);
      @(posedge clk_i);
      check("irq_cmp", 16'h0001, 16'(irq_cmp_o));
      wr(A_MSK, 8'h02);
      @(posedge clk_i);
      check("irq_cmp", 16'h0000, 16'(irq_cmp_o));
      wr(A_MSK, 8'h00);
      // clear on match keeps the counter from wrapping
      for (int c = 1; c >= 0; c--) begin
         wr(A_CTL, 8'h00);
         wr(A_FLG, 8'h03);
         wr(A_CNT, 8'h00);
         wr(A_CMP, 8'h05);
         wr(A_CTL, {1'(c), 7'h01});
         repeat (600) @(posedge clk_i);
         wr(A_CTL, 8'h00);
         rd(A_FLG, c ? 8'h02 : 8'h03);
      end
      wr(A_MSK, 8'h81);
      @(posedge clk_i);
      check("irq_ovf", 16'h0001, 16'(irq_ovf_o));
      wr(A_MSK, 8'h00);
      // count rate of source codes 1 to 8 over about 100 ticks
      for (int c = 1; c < 9; c++) begin
         wr(A_CNT, 8'h00);
         wr(A_CTL, 8'(c));
         repeat (100 << (c - 1)) @(posedge clk_i);
         wr(A_CTL, 8'h00);
         bus(1'b0, A_CNT, 8'h00, q);
         checks++;
         if ($isunknown(q) || q < 8'h63 || q > 8'h68) begin
            $display("unexpected count code %0d: expected 100 seen %0d",
                     c, q);
            n_errors++;
         end
      end
      // pwm: period of 64 ticks, duty from the compare value
      rs = xs(rs);
      cv = '{8'h00, 8'h15, {2'b00, rs[5:0]}, 8'h3F};
      wr(A_FLG, 8'h03);
      wr(A_DIR, 8'h01);
      wr(A_TOP, 8'h3F);
      rd(A_TOP, 8'h3F);
      wr(A_CNT, 8'h00);
      for (int a = 2; a < 4; a++) begin
         for (int i = 0; i < 4; i++) begin
            wr(A_CMP, cv[i]);
            rd(A_CMP, cv[i]);
            wr(A_CTL, {2'b01, 2'(a), 4'h1});
            repeat (192) @(posedge clk_i);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            repeat (128) @(posedge clk_i);
            #1;
            hi = (cv[i] == 8'h3F) ? 64 : int'(cv[i]);
            if (a == 3) hi = 64 - hi;
            check("high cycles", 16'(2 * hi), high_cnt);
         end
      end
      // PWM action 01 leaves the pin to the port
      wr(A_CTL, 8'h51);
      @(posedge clk_i);
      check("oe", 16'h0000, 16'(cmp_pin_oe_o));
      wr(A_MSK, 8'h81);
      @(posedge clk_i);
      check("irq_ovf", 16'h0001, 16'(irq_ovf_o));
      test_done();
   end
endmodule : tcfp_timer_tb_top
